// ===== sdpc_ctrl_model.sv
// Purpose: controller model driving cke and command pins
// Assumes: requests come from the bench
// Notes:   pins change only at the falling clock edge
`timescale 1ns/10ps
module sdpc_ctrl_model #(
   parameter int CKE_HOLD = 4
) (
   // clock
   input  wire logic                   sys_clk,
   // requests
   input  wire logic                   want_cke,
   input  wire sdpc_pkg::sdpc_cmd_type want_cmd,
   // memory pins
   output logic                        cke,
   output sdpc_pkg::sdpc_cmd_type      cmd_pins
);
   int hold_cnt = 0;
   initial begin
      cke      = 1'b0;
      cmd_pins = sdpc_pkg::CMD_NOP;
   end
   always @(negedge sys_clk) begin
      if (want_cke != cke && hold_cnt >= CKE_HOLD) begin
         cke      <= want_cke;
         hold_cnt <= 0;
         if (want_cmd.cs_n || want_cmd == sdpc_pkg::CMD_REFRESH)
            cmd_pins <= want_cmd;
         else
            cmd_pins <= sdpc_pkg::CMD_NOP;
      end else begin
         hold_cnt <= hold_cnt + 1;
         cmd_pins <= want_cmd;
      end
   end
endmodule // sdpc_ctrl_model

// ===== sdpc_pkg.sv
// Purpose: shared types and constants for the cke power-state logic
// Assumes: command pins sampled on the rising clock edge
// Notes:   command pins are active low as on the memory bus
package sdpc_pkg;

   // ******************************************************************
   // command encodings {cs_n, ras_n, cas_n, we_n}
   // ******************************************************************
   localparam logic [3:0] CMD_NOP     = 4'h7;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   localparam logic [3:0] CMD_DES_MSK = 4'h8;

   // ******************************************************************
   // timing counts
   // ******************************************************************
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      SDPC_IDLE,
      SDPC_ACTIVE,
      SDPC_BUSY,
      SDPC_APD,
      SDPC_PPD,
      SDPC_SREF
   } sdpc_state_type;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } sdpc_cmd_type;

   typedef struct packed {
      logic banks_open;
      logic burst_busy;
      logic precharging;
      logic refreshing;
      logic timing_ok;
   } sdpc_core_type;

endpackage

// ===== sdpc_sync.sv
// Purpose: two flip-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to sys_clk
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
module sdpc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset,
   // data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // elaboration-time refusal of an empty bus
   if (WIDTH < 1) begin : g_width_check
      $error("sdpc_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule // sdpc_sync

// ===== sdpc_top.sv
// Purpose: cke driven power-down and self refresh state logic
// Assumes: core status inputs come from logic on sys_clk
// Notes:   cke and command pins are synchronised before use
`timescale 1ns/10ps

module sdpc_top (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   // memory pins
   input  wire logic                   cke,
   input  wire sdpc_pkg::sdpc_cmd_type cmd_pins,
   input  wire logic                   odt,
   // core status
   input  wire sdpc_pkg::sdpc_core_type core,
   // state outputs
   output sdpc_pkg::sdpc_state_type     state,
   output logic                         power_down,
   output logic                         self_refresh,
   output logic                         idle,
   output logic                         cmd_accept,
   output logic                         illegal
);

   // ******************************************************************
   // pin synchronisation
   // ******************************************************************
   logic [4:0]            pins_s;
   logic                  cke_s;
   sdpc_pkg::sdpc_cmd_type cmd_s;

   sdpc_sync #(
      .WIDTH (5)
   ) u_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .din     ({cke, cmd_pins}),
      .dout    (pins_s)
   );

   assign cke_s = pins_s[4];
   assign cmd_s = pins_s[3:0];

   // ******************************************************************
   // state next-value logic
   // ******************************************************************
   sdpc_pkg::sdpc_state_type state_q, state_d;
   logic cke_prev_q, cke_prev_d;
   logic pd_q, pd_d, sr_q, sr_d, idle_q, idle_d, acc_q, acc_d;
   logic ill_q, ill_d;
   logic is_des, is_nop, quiet, is_ref, fall, rise, stay_low, all_idle;

   always_comb begin
      is_des   = cmd_s.cs_n;
      is_nop   = (cmd_s == sdpc_pkg::CMD_NOP);
      quiet    = is_des | is_nop;
      is_ref   = (cmd_s == sdpc_pkg::CMD_REFRESH);
      fall     = cke_prev_q & ~cke_s;
      rise     = ~cke_prev_q & cke_s;
      stay_low = ~cke_prev_q & ~cke_s;
      all_idle = ~core.banks_open & ~core.burst_busy & ~core.precharging
                 & ~core.refreshing & core.timing_ok;
      state_d  = state_q;
      ill_d    = 1'b0;
      // odt is deliberately not read here
      case (state_q)
         sdpc_pkg::SDPC_APD,
         sdpc_pkg::SDPC_PPD: begin
            if (rise & quiet) begin
               state_d = core.banks_open ? sdpc_pkg::SDPC_ACTIVE
                                         : sdpc_pkg::SDPC_IDLE;
            end else if (!stay_low) begin
               ill_d = 1'b1;
            end
         end
         sdpc_pkg::SDPC_SREF: begin
            if (rise & quiet) begin
               state_d = sdpc_pkg::SDPC_IDLE;
            end else if (!stay_low) begin
               ill_d = 1'b1;
            end
         end
         default: begin
            if (fall) begin
               if (quiet && (core.burst_busy || core.precharging)) begin
                  state_d = sdpc_pkg::SDPC_PPD;
               end else if (quiet && core.banks_open) begin
                  state_d = sdpc_pkg::SDPC_APD;
               end else if (quiet && (core.refreshing || all_idle)) begin
                  state_d = sdpc_pkg::SDPC_PPD;
               end else if (is_ref && all_idle) begin
                  state_d = sdpc_pkg::SDPC_SREF;
               end else begin
                  ill_d = 1'b1;
               end
            end else if (cke_s) begin
               if (core.banks_open | core.burst_busy | core.precharging
                   | core.refreshing) begin
                  state_d = core.banks_open ? sdpc_pkg::SDPC_ACTIVE
                                            : sdpc_pkg::SDPC_BUSY;
               end else begin
                  state_d = sdpc_pkg::SDPC_IDLE;
               end
            end
         end
      endcase
      cke_prev_d = cke_s;
      pd_d   = (state_d == sdpc_pkg::SDPC_APD)
             | (state_d == sdpc_pkg::SDPC_PPD);
      sr_d   = (state_d == sdpc_pkg::SDPC_SREF);
      idle_d = (state_d == sdpc_pkg::SDPC_IDLE) & all_idle & cke_s;
      acc_d  = cke_prev_q & cke_s & ~is_des & ~is_nop & ~pd_d & ~sr_d;
   end

   // ******************************************************************
   // state registers
   // ******************************************************************
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_q    <= sdpc_pkg::SDPC_IDLE;
         cke_prev_q <= 1'b0;
         pd_q       <= 1'b0;
         sr_q       <= 1'b0;
         idle_q     <= 1'b0;
         acc_q      <= 1'b0;
         ill_q      <= 1'b0;
      end else begin
         state_q    <= state_d;
         cke_prev_q <= cke_prev_d;
         pd_q       <= pd_d;
         sr_q       <= sr_d;
         idle_q     <= idle_d;
         acc_q      <= acc_d;
         ill_q      <= ill_d;
      end
   end

   assign state        = state_q;
   assign power_down   = pd_q;
   assign self_refresh = sr_q;
   assign idle         = idle_q;
   assign cmd_accept   = acc_q;
   assign illegal      = ill_q;

   // ******************************************************************
   // assertions
   // ******************************************************************
   apd_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
      (fall && quiet && core.banks_open && !core.burst_busy
       && !core.precharging && state_q inside {sdpc_pkg::SDPC_IDLE,
       sdpc_pkg::SDPC_ACTIVE, sdpc_pkg::SDPC_BUSY})
      |=> state_q == sdpc_pkg::SDPC_APD)
      else $error("active power-down not entered");

   pd_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
      (fall && quiet && core.burst_busy && !pd_q && !sr_q)
      |=> pd_q && state_q == sdpc_pkg::SDPC_PPD)
      else $error("power-down not entered while busy");

   ppd_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
      (fall && quiet && all_idle && !pd_q && !sr_q)
      |=> state_q == sdpc_pkg::SDPC_PPD)
      else $error("precharge power-down not entered");

   sref_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
      (fall && is_ref && all_idle && !pd_q && !sr_q)
      |=> sr_q && !pd_q)
      else $error("self refresh not entered");

   pd_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pd_q && stay_low) |=> $stable(state_q))
      else $error("power-down left while cke low");

   sref_exit_a: assert property (@(posedge sys_clk) disable iff (reset)
      (sr_q && rise && quiet) |=> !sr_q ##1 !sr_q)
      else $error("self refresh exit failed");

   des_block_a: assert property (@(posedge sys_clk) disable iff (reset)
      is_des |=> !cmd_accept)
      else $error("command accepted under deselect");

   illegal_flag_a: assert property (@(posedge sys_clk) disable iff (reset)
      (sr_q && cke_prev_q) |=> illegal && sr_q)
      else $error("illegal self refresh sequence not flagged");

   prev_cke_a: assert property (@(posedge sys_clk) disable iff (reset)
      cke_prev_q == $past(cke_s))
      else $error("previous cke sample wrong");

   pd_exit_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pd_q && rise && quiet) |=> !pd_q && !sr_q)
      else $error("power-down exit failed");

   sref_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      (sr_q && stay_low) |=> sr_q && !pd_q)
      else $error("self refresh left while cke low");

   nop_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
      is_nop |=> !cmd_accept)
      else $error("command accepted under nop");

   pd_refuse_a: assert property (@(posedge sys_clk) disable iff (reset)
      (pd_q && rise && !quiet) |=> pd_q && illegal)
      else $error("illegal power-down exit not refused");

endmodule // sdpc_top

// ===== sdpc_top_tb_top.sv
// Purpose: self-checking bench for the cke power-state logic
// Assumes: controller model drives cke and command pins, bench drives odt
// Notes:   pins reach the state outputs three cycles late
`timescale 1ns/10ps
module sdpc_top_tb_top;
   logic                     sys_clk  = 1'b0;
   logic                     reset    = 1'b1;
   logic                     want_cke = 1'b1;
   sdpc_pkg::sdpc_cmd_type   want_cmd = sdpc_pkg::CMD_NOP;
   logic                     odt      = 1'b0;
   sdpc_pkg::sdpc_core_type  core     = 5'h01;
   logic                     cke;
   sdpc_pkg::sdpc_cmd_type   cmd_pins;
   sdpc_pkg::sdpc_state_type state;
   logic                     pd, sr, idle, acc, ill;
   int num_errors = 0, cmp_count = 0, cycles = 0, acc_hits, ill_hits;

   always #50 sys_clk = ~sys_clk;

   sdpc_ctrl_model i_sdpc_ctrl_model (.sys_clk(sys_clk),
      .want_cke(want_cke), .want_cmd(want_cmd), .cke(cke),
      .cmd_pins(cmd_pins));
   sdpc_top i_sdpc_top (.sys_clk(sys_clk), .reset(reset), .cke(cke),
      .cmd_pins(cmd_pins), .odt(odt), .core(core), .state(state),
      .power_down(pd), .self_refresh(sr), .idle(idle),
      .cmd_accept(acc), .illegal(ill));

   always @(posedge sys_clk) begin
      cycles++;
      if (acc === 1'b1) acc_hits++;
      if (ill === 1'b1) ill_hits++;
      if (cycles == 2000) begin
         num_errors++;
         end_of_test();
      end
   end

   task automatic chk(input string name, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic edge_to(input logic c, input logic [3:0] cmd);
      want_cke <= c;
      want_cmd <= cmd;
      repeat (2) @(negedge sys_clk);
      want_cmd <= sdpc_pkg::CMD_NOP;
      repeat (8) @(negedge sys_clk);
   endtask

   task automatic look(input sdpc_pkg::sdpc_state_type s,
                       input logic p, r, i);
      chk("state", 8'(state), 8'(s));
      chk("power_down", {7'h00, pd}, {7'h00, p});
      chk("self_refresh", {7'h00, sr}, {7'h00, r});
      chk("idle", {7'h00, idle}, {7'h00, i});
   endtask

   task automatic one_cmd(input logic [3:0] cmd, input logic [7:0] n);
      acc_hits = 0;
      want_cmd <= cmd;
      @(negedge sys_clk) want_cmd <= sdpc_pkg::CMD_NOP;
      repeat (6) @(negedge sys_clk);
      chk("cmd_accept", 8'(acc_hits), n);
   endtask

   task automatic t_cmd;
      one_cmd(4'h3, 8'h01);
      one_cmd(4'hB, 8'h00);
      one_cmd(sdpc_pkg::CMD_NOP, 8'h00);
      $display("test commands done");
   endtask

   task automatic t_active;
      core <= 5'h11;
      edge_to(1'b0, sdpc_pkg::CMD_NOP);
      look(sdpc_pkg::SDPC_APD, 1'b1, 1'b0, 1'b0);
      odt <= 1'b1;
      edge_to(1'b1, sdpc_pkg::CMD_NOP);
      look(sdpc_pkg::SDPC_ACTIVE, 1'b0, 1'b0, 1'b0);
      $display("test active power-down done");
   endtask

   task automatic t_busy;
      core <= 5'h09;
      edge_to(1'b0, 4'hF);
      look(sdpc_pkg::SDPC_PPD, 1'b1, 1'b0, 1'b0);
      core <= 5'h01;
      edge_to(1'b1, 4'hF);
      look(sdpc_pkg::SDPC_IDLE, 1'b0, 1'b0, 1'b1);
      $display("test busy power-down done");
   endtask

   task automatic t_sref;
      edge_to(1'b0, sdpc_pkg::CMD_REFRESH);
      look(sdpc_pkg::SDPC_SREF, 1'b0, 1'b1, 1'b0);
      edge_to(1'b1, sdpc_pkg::CMD_NOP);
      look(sdpc_pkg::SDPC_IDLE, 1'b0, 1'b0, 1'b1);
      $display("test self refresh done");
   endtask

   task automatic t_illegal;
      core <= 5'h03;
      edge_to(1'b0, sdpc_pkg::CMD_NOP);
      look(sdpc_pkg::SDPC_PPD, 1'b1, 1'b0, 1'b0);
      ill_hits = 0;
      edge_to(1'b1, sdpc_pkg::CMD_REFRESH);
      look(sdpc_pkg::SDPC_PPD, 1'b1, 1'b0, 1'b0);
      // flag repeats each cycle power-down sees cke high
      chk("illegal", 8'(ill_hits), 8'h06);
      $display("test illegal exit done");
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      @(negedge sys_clk) reset <= 1'b0;
      repeat (8) @(negedge sys_clk);
      look(sdpc_pkg::SDPC_IDLE, 1'b0, 1'b0, 1'b1);
      t_cmd();
      t_active();
      t_busy();
      t_sref();
      t_illegal();
      end_of_test();
   end
endmodule // sdpc_top_tb_top
